// File: rtl/interval_timer.v
// Down-counter that times a programmed number of enable ticks.
// Assumes tick is a one-cycle enable on the same clock.
`timescale 1ns/100ps
`default_nettype none
module interval_timer #(
  parameter W = 16
) (
  input wire clk,
  input wire resetn,
  input wire start,
  input wire tick,
  input wire [W-1:0] count,
  output reg busy,
  output reg done
);
  reg [W-1:0] remain_r;

  // Loads on start, counts ticks, pulses done when the count runs out.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      remain_r <= {W{1'b0}};
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        remain_r <= count;
        busy <= 1'b1;
      end else if (busy && (remain_r <= {{(W-1){1'b0}}, 1'b1})) begin
        if (tick || remain_r == {W{1'b0}}) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end else if (busy && tick) begin
        remain_r <= remain_r - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule
`default_nettype wire

// File: rtl/receiver_control_status_timer_regs.v
// Control, status and sleep timer registers of the receiver digital core.
// Assumes the serial protocol decoder presents one-cycle write/read strobes on clk,
// and that analog status inputs arrive asynchronously from the analog front end.
// The serial data line has a pull-up, so a released line reads high once synchronised.
`timescale 1ns/100ps
`default_nettype none
`include "rx_ctrl_regs.vh"
module receiver_control_status_timer_regs #(
  parameter TICKS = `UNIT_TICKS
) (
  input wire clk,
  input wire resetn,
  input wire wrStb,
  input wire rdStb,
  input wire [3:0] addr,
  input wire [7:0] wrData,
  output reg [7:0] rdData,
  input wire synthLockedIn,
  input wire autoGainHighIn,
  input wire crystalClockPresentIn,
  input wire pollCalFinished,
  input wire freqCalFinished,
  input wire serialDataLineIn,
  output wire serialDataLineOut,
  output wire serialDataLineOe,
  output reg gainHigh,
  output wire freqDetectorTrackOn,
  output wire ampDetectorTrackOn,
  output reg pollCalRun,
  output reg freqCalRun,
  output reg rfSectionsOn,
  output reg peakDetectorsOn,
  output reg demodOutputsOn,
  output wire dataValid
);
  // Sequencer states, one-hot.
  localparam ST_CONT = 5'b00001;
  localparam ST_SLEEP = 5'b00010;
  localparam ST_WAKE = 5'b00100;
  localparam ST_SETTLE = 5'b01000;
  localparam ST_ACTIVE = 5'b10000;
  // Number of asynchronous inputs that pass the two-flop synchroniser.
  localparam SYNC_W = 6;

  // Host-visible register copies and calibration completion flags.
  reg [7:0] config_r;
  reg [7:0] control_r;
  reg [7:0] offHi_r;
  reg [7:0] offLo_r;
  reg [7:0] cpuRec_r;
  reg [7:0] rfHi_r;
  reg [7:0] rfLo_r;
  reg pollDone_r;
  reg freqDone_r;
  reg [4:0] state_r;
  reg [4:0] state_nxt;
  reg dataDrivenLow_r;
  // Timer enables and handshakes.
  wire baseTick;
  wire offTick;
  wire offBusy;
  wire offDone;
  wire wakeBusy;
  wire wakeDone;
  wire rfBusy;
  wire rfDone;
  wire synthLocked;
  wire gainAuto;
  wire crystalOk;
  wire lineLevel;
  wire pollFin;
  wire freqFin;
  wire intermittent;
  wire startSleep;
  wire startWake;
  wire startSettle;
  // Raw asynchronous inputs and their synchronised copies.
  wire [SYNC_W-1:0] asyncIn;
  wire [SYNC_W-1:0] syncOut;
  genvar gi;

  // Two-flop synchroniser per asynchronous input; only the second stage is read,
  // so a metastable first stage never reaches the register or sequencer logic.
  assign asyncIn = {freqCalFinished, pollCalFinished, serialDataLineIn,
    crystalClockPresentIn, autoGainHighIn, synthLockedIn};
  generate
    for (gi = 0; gi < SYNC_W; gi = gi + 1) begin : gSync
      reg firstFf_r;
      reg secondFf_r;
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          firstFf_r <= 1'b0;
          secondFf_r <= 1'b0;
        end else begin
          firstFf_r <= asyncIn[gi];
          secondFf_r <= firstFf_r;
        end
      end
      assign syncOut[gi] = secondFf_r;
    end
  endgenerate

  // Synchronised levels by name.
  assign synthLocked = syncOut[0];
  assign gainAuto = syncOut[1];
  assign crystalOk = syncOut[2];
  assign lineLevel = syncOut[3];
  assign pollFin = syncOut[4];
  assign freqFin = syncOut[5];
  assign intermittent = config_r[`CFG_INTERMITTENT];

  // Register writes and calibration handshakes.
  // The start bits sit outside the address case so that a written zero leaves a running
  // calibration alone and the hardware clear lands in the same cycle as the done flag.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      config_r <= `RST_BYTE;
      control_r <= `RST_BYTE;
      offHi_r <= `RST_BYTE;
      offLo_r <= `RST_BYTE;
      cpuRec_r <= `RST_BYTE;
      rfHi_r <= `RST_BYTE;
      rfLo_r <= `RST_BYTE;
      pollDone_r <= 1'b0;
      freqDone_r <= 1'b0;
    end else begin
      if (wrStb) begin
        case (addr)
          `ADDR_CONFIG: config_r <= wrData;
          `ADDR_CONTROL: begin
            control_r[`CTL_GAIN_FREEZE] <= wrData[`CTL_GAIN_FREEZE];
            control_r[`CTL_FREQ_TRACK] <= wrData[`CTL_FREQ_TRACK];
            control_r[`CTL_AMP_TRACK] <= wrData[`CTL_AMP_TRACK];
          end
          `ADDR_OFF_HI: offHi_r <= wrData;
          `ADDR_OFF_LO: offLo_r <= wrData;
          `ADDR_CPU_REC: cpuRec_r <= wrData;
          `ADDR_RF_HI: rfHi_r <= wrData;
          `ADDR_RF_LO: rfLo_r <= wrData;
          default: config_r <= config_r;
        endcase
      end
      // Start bits set only by a one; a written zero never aborts.
      if (wrStb && addr == `ADDR_CONTROL && wrData[`CTL_POLL_CAL]) begin
        control_r[`CTL_POLL_CAL] <= 1'b1;
        pollDone_r <= 1'b0;
      end else if (control_r[`CTL_POLL_CAL] && pollFin) begin
        control_r[`CTL_POLL_CAL] <= 1'b0;
        pollDone_r <= 1'b1;
      end
      if (wrStb && addr == `ADDR_CONTROL && wrData[`CTL_FREQ_CAL]) begin
        control_r[`CTL_FREQ_CAL] <= 1'b1;
        freqDone_r <= 1'b0;
      end else if (control_r[`CTL_FREQ_CAL] && freqFin) begin
        control_r[`CTL_FREQ_CAL] <= 1'b0;
        freqDone_r <= 1'b1;
      end
    end
  end

  // Outputs that follow control bits or the synchronised lock level directly.
  assign freqDetectorTrackOn = control_r[`CTL_FREQ_TRACK];
  assign ampDetectorTrackOn = control_r[`CTL_AMP_TRACK];
  assign dataValid = synthLocked;

  // Calibration run levels and amplifier gain, frozen while gain freeze is set.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gainHigh <= `RST_GAIN_HIGH;
      pollCalRun <= 1'b0;
      freqCalRun <= 1'b0;
    end else begin
      pollCalRun <= control_r[`CTL_POLL_CAL];
      freqCalRun <= control_r[`CTL_FREQ_CAL];
      if (!control_r[`CTL_GAIN_FREEZE]) begin
        gainHigh <= gainAuto;
      end
    end
  end

  // Read mux; the status register reflects live state.
  // Unmapped addresses read as zero; the read data holds until the next read strobe.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdData <= `RST_BYTE;
    end else if (rdStb) begin
      case (addr)
        `ADDR_CONFIG: rdData <= config_r;
        `ADDR_CONTROL: rdData <= control_r;
        `ADDR_OFF_HI: rdData <= offHi_r;
        `ADDR_OFF_LO: rdData <= offLo_r;
        `ADDR_CPU_REC: rdData <= cpuRec_r;
        `ADDR_RF_HI: rdData <= rfHi_r;
        `ADDR_RF_LO: rdData <= rfLo_r;
        `ADDR_STATUS: begin
          rdData <= `RST_BYTE;
          rdData[`STS_LOCKED] <= synthLocked;
          rdData[`STS_GAIN] <= gainHigh;
          rdData[`STS_XTAL] <= crystalOk;
          rdData[`STS_POLL_DONE] <= pollDone_r;
          rdData[`STS_FREQ_DONE] <= freqDone_r;
        end
        default: rdData <= `RST_BYTE;
      endcase
    end
  end

  // Time base and the three interval timers.
  // The divider runs freely, so the first unit of an interval may be short; a count of
  // one therefore lasts at most one unit, and a count of zero ends at once.
  unit_tick_gen #(
    .TICKS(TICKS)
  ) uTick (
    .clk(clk),
    .resetn(resetn),
    .unitSel(config_r[`CFG_UNIT_HI:`CFG_UNIT_LO]),
    .baseTick(baseTick),
    .offTick(offTick)
  );

  interval_timer #(
    .W(16)
  ) uOff (
    .clk(clk),
    .resetn(resetn),
    .start(startSleep),
    .tick(offTick),
    .count({offHi_r, offLo_r}),
    .busy(offBusy),
    .done(offDone)
  );

  interval_timer #(
    .W(8)
  ) uWake (
    .clk(clk),
    .resetn(resetn),
    .start(startWake),
    .tick(baseTick),
    .count(cpuRec_r),
    .busy(wakeBusy),
    .done(wakeDone)
  );

  interval_timer #(
    .W(16)
  ) uSettle (
    .clk(clk),
    .resetn(resetn),
    .start(startSettle),
    .tick(baseTick),
    .count({rfHi_r, rfLo_r}),
    .busy(rfBusy),
    .done(rfDone)
  );

  // Intermittent receive sequencer next-state logic.
  // Wake and settle always run to their end, so the data line is never released half way
  // through; leaving intermittent receive takes effect from sleep or active only.
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_CONT: begin
        if (intermittent) begin
          state_nxt = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (!intermittent) begin
          state_nxt = ST_CONT;
        end else if (offDone) begin
          state_nxt = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (wakeDone) begin
          state_nxt = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (rfDone) begin
          state_nxt = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (!intermittent) begin
          state_nxt = ST_CONT;
        end else if (lineLevel) begin
          state_nxt = ST_SLEEP;
        end
      end
      default: state_nxt = ST_CONT;
    endcase
  end

  // Each timer is loaded in the cycle in which its state is entered.
  assign startSleep = (state_nxt == ST_SLEEP) && (state_r != ST_SLEEP);
  assign startWake = (state_nxt == ST_WAKE) && (state_r != ST_WAKE);
  assign startSettle = (state_nxt == ST_SETTLE) && (state_r != ST_SETTLE);

  // Sequencer state and power/output enables.
  // Enables are registered from the next state so they switch together with the state.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_CONT;
      rfSectionsOn <= 1'b0;
      peakDetectorsOn <= 1'b0;
      demodOutputsOn <= 1'b0;
      dataDrivenLow_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rfSectionsOn <= state_nxt[0] | state_nxt[3] | state_nxt[4];
      peakDetectorsOn <= state_nxt[0] | state_nxt[4];
      demodOutputsOn <= state_nxt[0] | state_nxt[4];
      dataDrivenLow_r <= state_nxt[2] | state_nxt[3];
    end
  end

  // Data line is pulled low during wake and settle, released afterwards.
  // Only a low is ever driven; the pull-up supplies the high level.
  assign serialDataLineOut = 1'b0;
  assign serialDataLineOe = dataDrivenLow_r;
endmodule
`default_nettype wire

// File: rtl/rx_ctrl_regs.vh
// Register map, field positions and timing constants of the receiver control bank.
// Included by the register bank and its time-base divider; definitions only.
`ifndef RX_CTRL_REGS_VH
`define RX_CTRL_REGS_VH

// Register addresses on the configuration port.
`define ADDR_CONFIG 4'h1
`define ADDR_CONTROL 4'h2
`define ADDR_OFF_HI 4'h4
`define ADDR_OFF_LO 4'h5
`define ADDR_CPU_REC 4'h6
`define ADDR_RF_HI 4'h7
`define ADDR_RF_LO 4'h8
`define ADDR_STATUS 4'h9

// Control register fields.
`define CTL_GAIN_FREEZE 6
`define CTL_FREQ_TRACK 3
`define CTL_AMP_TRACK 2
`define CTL_POLL_CAL 1
`define CTL_FREQ_CAL 0

// Status register fields.
`define STS_LOCKED 7
`define STS_GAIN 6
`define STS_XTAL 5
`define STS_POLL_DONE 1
`define STS_FREQ_DONE 0

// Configuration register fields.
`define CFG_UNIT_HI 2
`define CFG_UNIT_LO 1
`define CFG_INTERMITTENT 0

// Reset values.
`define RST_BYTE 8'h00
`define RST_GAIN_HIGH 1'b1

// Base time unit in ns, clock period in ns, and prescale divider tops (multiplier minus one).
`define BASE_UNIT_NS 120000
`define CLK_PERIOD_NS 25
`define UNIT_TICKS (`BASE_UNIT_NS / `CLK_PERIOD_NS)
`define PRESCALE_X1 2'h0
`define PRESCALE_X4 2'h1
`define PRESCALE_X16 2'h2
`define PRE_TOP_X4 6'h03
`define PRE_TOP_X16 6'h0f
`define PRE_TOP_X64 6'h3f

`endif

// File: rtl/unit_tick_gen.v
// Time-base divider: one-cycle enable pulse every base unit and every prescaled unit.
// Assumes a single free-running clock and asynchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
`include "rx_ctrl_regs.vh"
module unit_tick_gen #(
  parameter TICKS = `UNIT_TICKS
) (
  input wire clk,
  input wire resetn,
  input wire [1:0] unitSel,
  output reg baseTick,
  output reg offTick
);
  reg [15:0] divCnt_r;
  reg [5:0] preCnt_r;
  reg [5:0] preTop;

  // Prescaled tick divides the base tick by 1, 4, 16 or 64.
  always @* begin
    case (unitSel)
      `PRESCALE_X1: preTop = 6'h00;
      `PRESCALE_X4: preTop = `PRE_TOP_X4;
      `PRESCALE_X16: preTop = `PRE_TOP_X16;
      default: preTop = `PRE_TOP_X64;
    endcase
  end

  // Counters produce the base and off-time enables.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      divCnt_r <= 16'h0000;
      preCnt_r <= 6'h00;
      baseTick <= 1'b0;
      offTick <= 1'b0;
    end else begin
      baseTick <= 1'b0;
      offTick <= 1'b0;
      if (divCnt_r == TICKS - 1) begin
        divCnt_r <= 16'h0000;
        baseTick <= 1'b1;
        if (preCnt_r >= preTop) begin
          preCnt_r <= 6'h00;
          offTick <= 1'b1;
        end else begin
          preCnt_r <= preCnt_r + 6'h01;
        end
      end else begin
        divCnt_r <= divCnt_r + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// File: verification/host_model.sv
// Host side of the serial data line, with the line's pull-up.
// Assumes the device pulls the line low only while its enable is high.
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input wire logic devOe,
  input wire logic holdLow,
  output logic lineLevel
);
  // The pull-up wins unless the device or the host holds the line low.
  assign lineLevel = !(devOe || holdLow);
endmodule
`default_nettype wire

// File: verification/rx_regs_sva.sv
// Concurrent checks on the ports of the receiver control bank.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/100ps
`default_nettype none
module rx_regs_sva (
  input wire logic clk,
  input wire logic resetn,
  input wire logic wrStb,
  input wire logic rdStb,
  input wire logic [3:0] addr,
  input wire logic [7:0] wrData,
  input wire logic [7:0] rdData,
  input wire logic synthLockedIn,
  input wire logic crystalClockPresentIn,
  input wire logic pollCalFinished,
  input wire logic freqCalFinished,
  input wire logic serialDataLineOut,
  input wire logic serialDataLineOe,
  input wire logic gainHigh,
  input wire logic freqDetectorTrackOn,
  input wire logic ampDetectorTrackOn,
  input wire logic pollCalRun,
  input wire logic freqCalRun,
  input wire logic peakDetectorsOn,
  input wire logic demodOutputsOn,
  input wire logic dataValid
);
  logic freeze_r;
  wire ctlWr = wrStb && addr == 4'h2;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Shadow of the gain freeze bit, taken from host writes.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      freeze_r <= 1'b0;
    end else if (ctlWr) begin
      freeze_r <= wrData[6];
    end
  end
  AST_GAIN_FROZEN: assert property ($past(freeze_r) |-> $stable(gainHigh))
    else $error("gain moved while frozen");
  AST_FREQ_TRACK: assert property (ctlWr |=> freqDetectorTrackOn == $past(wrData[3]))
    else $error("freq tracking not set by write");
  AST_AMP_TRACK: assert property (ctlWr |=> ampDetectorTrackOn == $past(wrData[2]))
    else $error("amp tracking not set by write");
  AST_POLL_START: assert property (ctlWr && wrData[1] && !pollCalFinished |-> ##2 pollCalRun)
    else $error("poll calibration did not start");
  AST_POLL_CLEAR: assert property ($rose(pollCalFinished) && pollCalRun |-> ##[2:6] !pollCalRun)
    else $error("poll start bit did not self-clear");
  AST_FREQ_CLEAR: assert property ($rose(freqCalFinished) && freqCalRun |-> ##[2:6] !freqCalRun)
    else $error("freq start bit did not self-clear");
  AST_NO_ABORT: assert property ((!freqCalFinished)[*4] ##0 (ctlWr && !wrData[0] && freqCalRun)
    |-> ##2 freqCalRun)
    else $error("writing zero aborted calibration");
  AST_LOCK_DATA: assert property ((!synthLockedIn)[*4] |-> !dataValid)
    else $error("data valid while unlocked");
  AST_STATUS_RD: assert property ((synthLockedIn && crystalClockPresentIn)[*4] ##0
    (rdStb && addr == 4'h9) |=> rdData[7] && rdData[5])
    else $error("status lock or crystal bit wrong");
  AST_SETTLE_QUIET: assert property (serialDataLineOe |-> !peakDetectorsOn && !demodOutputsOn
    && !serialDataLineOut)
    else $error("outputs active while line held");
  cover property (ctlWr && wrData[0]);
  cover property ($fell(serialDataLineOe));
  cover property (pollCalRun && freqCalRun);
endmodule
bind receiver_control_status_timer_regs rx_regs_sva u_rx_regs_sva (.*);
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench for the receiver control bank.
// Assumes the design under rtl and the host model beside this file.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk = 0, resetn = 0, wrStb = 0, rdStb = 0, rdPend = 0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wrData = 8'h00;
  logic synthLockedIn = 1, autoGainHighIn = 0, crystalClockPresentIn = 1;
  logic pollCalFinished = 0, freqCalFinished = 0, hostHold = 0;
  wire [7:0] rdData;
  wire serialDataLineIn, serialDataLineOut, serialDataLineOe, gainHigh, dataValid;
  wire freqDetectorTrackOn, ampDetectorTrackOn, pollCalRun, freqCalRun;
  wire rfSectionsOn, peakDetectorsOn, demodOutputsOn;
  logic [15:0] expQ[$];
  logic [15:0] note;
  logic [7:0] v [4:8];
  int err_total = 0, tests_run = 0, n;

  receiver_control_status_timer_regs #(.TICKS(4)) u_receiver_control_status_timer_regs (.*);
  host_model u_host_model (.devOe(serialDataLineOe), .holdLow(hostHold),
    .lineLevel(serialDataLineIn));

  // Free-running clock at the core rate.
  always #12.5 clk = ~clk;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wrStb <= 1'b1;
    addr <= a;
    wrData <= d;
    @(posedge clk);
    wrStb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk);
    rdStb <= 1'b1;
    addr <= a;
    expQ.push_back({m, e & m});
    @(posedge clk);
    rdStb <= 1'b0;
  endtask
  task automatic waitc(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic close_out;
    $display("checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Each read answer is matched against the oldest note.
  always @(posedge clk) begin
    rdPend <= rdStb;
    if (rdPend) begin
      note = expQ.pop_front();
      check(rdData & note[15:8], note[7:0]);
    end
  end

  // Cuts a hang short.
  initial begin
    #(25 * 5000);
    err_total++;
    close_out();
  end

  // Main sequence.
  initial begin
    n = $urandom(7922);
    waitc(8);
    check(8'(gainHigh), 8'h01);
    resetn <= 1'b1;
    waitc(4);
    rd(4'h2, 8'h00, 8'h4f);
    rd(4'h7, 8'h00, 8'hff);
    rd(4'h8, 8'h00, 8'hff);
    rd(4'h9, 8'ha0, 8'he3);
    $display("power-up test done");
    for (int a = 4; a <= 8; a++) begin
      v[a] = 8'($urandom);
      wr(4'(a), v[a]);
    end
    for (int a = 4; a <= 8; a++) rd(4'(a), v[a], 8'hff);
    wr(4'h1, 8'hf6);
    rd(4'h1, 8'hf6, 8'hff);
    wr(4'h9, 8'h1f);
    rd(4'h9, 8'ha0, 8'he3);
    rd(4'h3, 8'h00, 8'hff);
    $display("register test done");
    wr(4'h2, 8'h0c);
    waitc(1);
    check(8'({freqDetectorTrackOn, ampDetectorTrackOn}), 8'h03);
    wr(4'h2, 8'h04);
    waitc(1);
    check(8'({freqDetectorTrackOn, ampDetectorTrackOn}), 8'h01);
    wr(4'h2, 8'h40);
    autoGainHighIn <= 1'b1;
    waitc(6);
    check(8'(gainHigh), 8'h00);
    rd(4'h9, 8'ha0, 8'he3);
    wr(4'h2, 8'h00);
    waitc(6);
    check(8'(gainHigh), 8'h01);
    rd(4'h9, 8'he0, 8'he3);
    synthLockedIn <= 1'b0;
    crystalClockPresentIn <= 1'b0;
    waitc(4);
    check(8'(dataValid), 8'h00);
    rd(4'h9, 8'h40, 8'he3);
    synthLockedIn <= 1'b1;
    crystalClockPresentIn <= 1'b1;
    waitc(4);
    check(8'(dataValid), 8'h01);
    $display("control test done");
    wr(4'h2, 8'h03);
    wr(4'h2, 8'h00);
    rd(4'h2, 8'h03, 8'h03);
    rd(4'h9, 8'h00, 8'h03);
    freqCalFinished <= 1'b1;
    waitc(5);
    rd(4'h2, 8'h02, 8'h03);
    rd(4'h9, 8'h01, 8'h03);
    pollCalFinished <= 1'b1;
    waitc(5);
    rd(4'h2, 8'h00, 8'h03);
    rd(4'h9, 8'h03, 8'h03);
    pollCalFinished <= 1'b0;
    freqCalFinished <= 1'b0;
    $display("calibration test done");
    wr(4'h4, 8'h00);
    wr(4'h5, 8'h01);
    wr(4'h6, 8'h02);
    wr(4'h7, 8'h00);
    wr(4'h8, 8'h03);
    check(8'(demodOutputsOn), 8'h01);
    hostHold <= 1'b1;
    wr(4'h1, 8'h01);
    n = 0;
    while (serialDataLineOe !== 1'b1 && n < 400) begin
      waitc(1);
      n++;
    end
    check(8'(n < 400), 8'h01);
    check(8'({rfSectionsOn, peakDetectorsOn}), 8'h00);
    n = 0;
    while (serialDataLineOe === 1'b1 && n < 400) begin
      waitc(1);
      n++;
    end
    check(8'(n >= 10 && n <= 26), 8'h01);
    check(8'({rfSectionsOn, peakDetectorsOn}), 8'h03);
    waitc(6);
    check(8'(demodOutputsOn), 8'h01);
    hostHold <= 1'b0;
    waitc(6);
    check(8'(demodOutputsOn), 8'h00);
    wr(4'h1, 8'h00);
    waitc(4);
    $display("intermittent test done");
    close_out();
  end
endmodule
`default_nettype wire
